/* File: rtl/isx_exec.sv */
// Executer for increment, increment-skip-zero and bit-test-skip-clear ops
`timescale 1ns/100ps
module isx_exec (
    input wire logic mclk,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [isx_pkg::INSTR_W-1:0] instr,
    input wire logic [isx_pkg::DATA_W-1:0] fileRdData,
    output logic [isx_pkg::ADDR_W-1:0] fileAddr,
    output logic fileWrEn,
    output logic [isx_pkg::DATA_W-1:0] fileWrData,
    output logic [isx_pkg::DATA_W-1:0] wReg,
    output logic zeroFlag,
    output logic discardNext,
    output logic busy
);
    import isx_pkg::*;

    typedef struct packed {
        isx_state_t st;
        logic [7:0] w;
        logic z;
        logic fwe;
        logic [4:0] fa;
        logic [7:0] fwd;
    } isx_reg_t;

    isx_reg_t r_q;
    isx_reg_t r_d;
    logic [7:0] incSum;
    logic incZero;
    logic isInc;
    logic isIncSz;
    logic isBtsc;
    logic destFile;
    logic bitClear;
    logic takeSkip;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    assign isInc = instrValid && (instr[11:6] == OPC_INC);
    assign isIncSz = instrValid && (instr[11:6] == OPC_INCSZ);
    assign isBtsc = instrValid && (instr[11:8] == OPC_BTSC);
    assign destFile = instr[DEST_POS];
    assign fileAddr = instr[ADDR_W-1:0];
    // High when the selected bit of the addressed file is clear
    assign bitClear = !fileRdData[instr[BIT_LSB+2:BIT_LSB]];

    isx_alu uAlu (
        .operand(fileRdData),
        .sum(incSum),
        .isZero(incZero)
    );

    // Skip decision made while the op is executing
    assign takeSkip = (r_q.st == ISX_EXEC) &&
        ((isIncSz && incZero) || (isBtsc && bitClear));

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.fwe = 1'b0;
        unique case (r_q.st)
            ISX_EXEC: begin
                if (isInc || isIncSz) begin
                    if (destFile) begin
                        r_d.fwe = 1'b1;
                        r_d.fa = fileAddr;
                        r_d.fwd = incSum;
                    end else begin
                        r_d.w = incSum;
                    end
                end
                // Only the plain increment touches status
                if (isInc) begin
                    r_d.z = incZero;
                end
                if (takeSkip) begin
                    r_d.st = ISX_FLUSH;
                end
            end
            ISX_FLUSH: begin
                // Fetched word is dropped, acting as a no-op
                r_d.st = ISX_EXEC;
            end
            default: begin
                // Unused code after an upset, fall back to execute
                r_d.st = ISX_EXEC;
            end
        endcase
    end

    // Registered state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q <= '{st: ISX_EXEC, w: WREG_RST, z: ZERO_RST, fwe: 1'b0,
                     fa: 5'h00, fwd: 8'h00};
        end else begin
            r_q <= r_d;
        end
    end

    assign wReg = r_q.w;
    assign zeroFlag = r_q.z;
    assign fileWrEn = r_q.fwe;
    assign fileWrData = r_q.fwd;
    // Handshake outputs: tell fetch the word now present is squashed
    assign discardNext = (r_q.st == ISX_FLUSH);
    assign busy = (r_q.st == ISX_FLUSH);

    // ----------------------------------------
    // Checks: increment-register op
    // ----------------------------------------
    // Result routing, zero flag and the write address held for the late file write
    AST_INC_W: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isInc && !destFile) |=>
        wReg == $past(fileRdData) + 8'h01)
        else $error("increment did not load W");

    AST_INC_F: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isInc && destFile) |=>
        fileWrEn && fileWrData == $past(fileRdData) + 8'h01)
        else $error("increment did not write the file");

    AST_INC_Z: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isInc) |=>
        zeroFlag == ($past(fileRdData) == 8'hFF))
        else $error("increment zero flag wrong");

    AST_INC_NOSKIP: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isInc) |=>
        !discardNext)
        else $error("plain increment squashed a word");

    AST_WRAP: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isInc && !destFile && fileRdData == 8'hFF) |=>
        wReg == 8'h00 && zeroFlag)
        else $error("increment did not wrap");

    AST_WR_ADDR: assert property (@(posedge mclk) disable iff (rst)
        fileWrEn |->
        r_q.fa == $past(fileAddr))
        else $error("file write address not the one read");

    // ----------------------------------------
    // Checks: increment-skip-zero op
    // ----------------------------------------
    // Same datapath as the plain op, but status must stay put
    AST_INCSZ_W: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isIncSz && !destFile) |=>
        wReg == $past(fileRdData) + 8'h01)
        else $error("skip increment did not load W");

    AST_INCSZ_F: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isIncSz && destFile) |=>
        fileWrEn && fileWrData == $past(incSum))
        else $error("skip increment file write missing");

    AST_INCSZ_NOZ: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isIncSz) |=>
        $stable(zeroFlag))
        else $error("skip increment changed status");

    AST_INCSZ_SKIP: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isIncSz && fileRdData == 8'hFF) |=>
        discardNext ##1 !discardNext)
        else $error("zero result did not skip once");

    AST_INCSZ_NOSKIP: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isIncSz && fileRdData != 8'hFF) |=>
        !discardNext)
        else $error("nonzero result skipped");

    AST_WRAP_SKIP: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isIncSz && destFile && fileRdData == 8'hFF) |=>
        fileWrData == 8'h00 && discardNext)
        else $error("wrapped skip increment wrong");

    // ----------------------------------------
    // Checks: bit-test-skip-clear op
    // ----------------------------------------
    // Pure test, so no write port, W or zero flag may move
    AST_BTSC_SKIP: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isBtsc && bitClear) |=>
        discardNext)
        else $error("clear bit did not skip");

    AST_BTSC_ONCE: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isBtsc && bitClear) |->
        ##2 !discardNext)
        else $error("bit test skip lasted too long");

    AST_BTSC_NOSKIP: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isBtsc && !bitClear) |=>
        !discardNext)
        else $error("set bit skipped");

    AST_BTSC_QUIET: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ISX_EXEC && isBtsc) |=>
        !fileWrEn && $stable(wReg) && $stable(zeroFlag))
        else $error("bit test changed state");

    // ----------------------------------------
    // Checks: squashed word
    // ----------------------------------------
    // The dead cycle must leave no trace, else the skip would leak effects
    AST_FLUSH_QUIET: assert property (@(posedge mclk) disable iff (rst)
        discardNext |=>
        !fileWrEn && $stable(wReg))
        else $error("flushed word had effect");

    AST_FLUSH_Z: assert property (@(posedge mclk) disable iff (rst)
        discardNext |=>
        $stable(zeroFlag))
        else $error("flushed word changed status");

    AST_FLUSH_ONE: assert property (@(posedge mclk) disable iff (rst)
        discardNext |=>
        !discardNext)
        else $error("skip cost more than one cycle");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    // Main scenarios the random stream must reach
    COV_INC: cover property (@(posedge mclk) disable iff (rst) r_q.st == ISX_EXEC && isInc);
    COV_INCSZ_SKIP: cover property (@(posedge mclk) disable iff (rst) isIncSz && takeSkip);
    COV_BTSC_SKIP: cover property (@(posedge mclk) disable iff (rst) isBtsc && takeSkip);
    COV_BTSC_NOSKIP: cover property (@(posedge mclk) disable iff (rst) isBtsc && !bitClear);
    COV_INCSZ_NOSKIP: cover property (@(posedge mclk) disable iff (rst) isIncSz && !incZero);
endmodule

/* File: rtl/isx_pkg.sv */
// Package of encodings and constants for the increment and skip executer
// Notes on behaviour
// - Increment-register op adds one to the file value, writes W when d is 0 else the file, and updates zero.
// - Increment-skip-zero op adds one and routes by d but leaves every status flag alone.
// - A zero result of increment-skip-zero discards the fetched next word and runs a no-op, two cycles.
// - A taken bit-test-skip-clear replaces the prefetched word with a no-op, two cycles, else one.
// - Bit-test-skip-clear carries a 3-bit index and 5-bit address and skips when that bit is 0.
package isx_pkg;
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    // Opcode fields compared against instr[11:6] or instr[11:8]
    localparam logic [5:0] OPC_INC = 6'h0A;
    localparam logic [5:0] OPC_INCSZ = 6'h0F;
    localparam logic [3:0] OPC_BTSC = 4'h6;
    localparam int DEST_POS = 5;
    localparam int BIT_LSB = 5;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    typedef enum logic [1:0] {
        ISX_EXEC = 2'h0,
        ISX_FLUSH = 2'h1
    } isx_state_t;
endpackage

/* File: rtl/isx_alu.sv */
// Incrementer with zero detect
`timescale 1ns/100ps
module isx_alu (
    input wire logic [7:0] operand,
    output logic [7:0] sum,
    output logic isZero
);
    import isx_pkg::*;
    // Wraps naturally at 8 bits
    assign sum = operand + 8'h01;
    assign isZero = (sum == 8'h00);
endmodule

/* File: sim/isx_file_model.sv */
// Register file model: combinational read, late write, forwarding
`timescale 1ns/100ps
module isx_file_model (
    input wire logic mclk,
    input wire logic [4:0] fileAddr,
    input wire logic fileWrEn,
    input wire logic [7:0] fileWrData,
    output logic [7:0] fileRdData
);
    logic [7:0] mem [32];
    logic [4:0] lastAddrQ;
    // Seeded near the wrap point so increments often reach zero
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'hFE + 8'(i % 4);
        end
    end
    // The write lands at the previous word's address
    always @(posedge mclk) begin
        lastAddrQ <= fileAddr;
        if (fileWrEn) mem[lastAddrQ] <= fileWrData;
    end
    // Forwarding, else a back-to-back read would see stale data
    assign fileRdData = (fileWrEn && lastAddrQ == fileAddr) ? fileWrData : mem[fileAddr];
endmodule

/* File: sim/tb_increment_skip_instr_exec.sv */
// Random self-checking bench for the increment and skip executer
`timescale 1ns/100ps
module tb_increment_skip_instr_exec;
    logic mclk = 0, rst = 1, instrValid = 0, fileWrEn, zeroFlag, discardNext, busy;
    logic [11:0] instr = '0;
    logic [7:0] fileRdData, fileWrData, wReg, v, eWd, eW = '0, sh [32];
    logic [4:0] fileAddr;
    logic eZ = 0, eSkip = 0, eWe = 0;
    int nErrors = 0, checked = 0, cycles = 0;
    isx_exec u_isx_exec (.mclk(mclk), .rst(rst), .instrValid(instrValid), .instr(instr),
        .fileRdData(fileRdData), .fileAddr(fileAddr), .fileWrEn(fileWrEn),
        .fileWrData(fileWrData), .wReg(wReg), .zeroFlag(zeroFlag),
        .discardNext(discardNext), .busy(busy));
    isx_file_model u_isx_file_model (.mclk(mclk), .fileAddr(fileAddr), .fileWrEn(fileWrEn),
        .fileWrData(fileWrData), .fileRdData(fileRdData));
    initial begin
        forever #25 mclk = ~mclk;
    end
    // Hang guard, well above the words issued
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nErrors++;
            test_done();
        end
    end
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("checked %0d nErrors %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Increment wrapping at 256, zero indication on top
    function automatic logic [8:0] incZ(logic [7:0] a);
        return {a + 8'h01 == 8'h00, a + 8'h01};
    endfunction
    // Random words of the three ops and a foreign one, squashes included
    initial begin
        logic [8:0] r;
        logic [1:0] k;
        void'($urandom(91));
        for (int i = 0; i < 32; i++) sh[i] = 8'hFE + 8'(i % 4);
        repeat (2) @(negedge mclk);
        chk("wReg", eW, wReg);
        chk("zeroFlag", {7'h0, eZ}, {7'h0, zeroFlag});
        rst = 0;
        repeat (2000) begin
            k = 2'($urandom);
            instr = {k == 0 ? 6'h0A : k == 1 ? 6'h0F : k == 2 ? {4'h6, 2'($urandom)} : 6'h3F,
                6'($urandom)};
            instrValid = ($urandom % 8) != 0;
            v = sh[instr[4:0]];
            r = incZ(v);
            eWe = 0;
            if (instrValid && !eSkip && k < 2) begin
                if (instr[5]) begin
                    eWe = 1;
                    eWd = r[7:0];
                    sh[instr[4:0]] = r[7:0];
                end else eW = r[7:0];
                if (k == 0) eZ = r[8];
                eSkip = k == 1 && r[8];
            end else eSkip = instrValid && !eSkip && k == 2 && !v[instr[7:5]];
            @(negedge mclk);
            chk("wReg", eW, wReg);
            chk("zeroFlag", {7'h0, eZ}, {7'h0, zeroFlag});
            chk("discardNext", {7'h0, eSkip}, {7'h0, discardNext});
            chk("fileWrEn", {7'h0, eWe}, {7'h0, fileWrEn});
            chk("busy", {7'h0, eSkip}, {7'h0, busy});
            if (eWe) chk("fileWrData", eWd, fileWrData);
        end
        test_done();
    end
endmodule
